// File: include/sdwc_pkg.sv
// package: command encodings, timing counts and carriers for the dram host
package sdwc_pkg;
   localparam int CLK_MHZ          = 10;
   localparam int REFI_NORM_NS     = 7800;
   localparam int REFI_HOT_NS      = 3900;
   // longest times round down
   localparam int REFI_NORM_CYC    = REFI_NORM_NS * CLK_MHZ / 1000;
   localparam int REFI_HOT_CYC     = REFI_HOT_NS * CLK_MHZ / 1000;
   localparam int RFC_NS           = 260;
   localparam int RP_NS            = 14;
   // least times round up
   localparam int RFC_CYC          = (RFC_NS * CLK_MHZ + 999) / 1000;
   localparam int RP_CYC           = (RP_NS * CLK_MHZ + 999) / 1000;
   localparam int VREF_WR_CLKS     = 512;
   localparam int MAX_POSTED       = 8;
   localparam int MAX_REF_BURST    = 16;
   localparam int ALLBANK_BIT      = 10;
   localparam int BURST_SEL_BIT    = 12;
   localparam int BEATS_CHOP       = 4;
   localparam int BEATS_FULL       = 8;

   // command pins cs_n, ras_n, cas_n, we_n
   localparam logic [3:0] CMD_DESELECT = 4'hF;
   localparam logic [3:0] CMD_NOP      = 4'h7;
   localparam logic [3:0] CMD_WRITE    = 4'h4;
   localparam logic [3:0] CMD_PRECHG   = 4'h2;
   localparam logic [3:0] CMD_REFRESH  = 4'h1;

   typedef enum logic [1:0] {
      SDWC_REQ_WRITE   = 2'h0,
      SDWC_REQ_PRECHG  = 2'h1,
      SDWC_REQ_SELFREF = 2'h2,
      SDWC_REQ_SREXIT  = 2'h3
   } sdwc_req_kind_t;

   typedef struct packed {
      logic [3:0]  cmd;
      logic [2:0]  bank;
      logic [13:0] addr;
      logic        cke;
   } sdwc_cmd_t;

   typedef struct packed {
      sdwc_req_kind_t kind;
      logic [2:0]     bank;
      logic [9:0]     col;
      logic           autoclose;
      logic           full_burst;
      logic           all_banks;
   } sdwc_req_t;
endpackage : sdwc_pkg

// File: hw/sdwc_refresh_sched.sv
// refresh debt tracking: interval timer, posted count and burst window
`timescale 1ns/10ps
module sdwc_refresh_sched
   import sdwc_pkg::*;
#(
   parameter int REFI_NORM = REFI_NORM_CYC,
   parameter int REFI_HOT  = REFI_HOT_CYC
) (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   // control
   input  wire logic       i_hot,
   input  wire logic       i_ref_issued,
   input  wire logic       i_in_selfref,
   // status
   output logic            o_need,
   output logic            o_urgent,
   output logic            o_window_ok
);
   initial begin
      if (REFI_HOT < 2 || REFI_NORM < REFI_HOT || REFI_NORM > 65536)
         $error("sdwc_refresh_sched: bad refresh interval");
   end

   logic [15:0] tick_q;
   logic [3:0]  owed_q;
   logic [16:0] win_q;
   logic [4:0]  win_cnt_q;
   logic [15:0] limit;

   assign limit = i_hot ? 16'(REFI_HOT - 1) : 16'(REFI_NORM - 1);

   // debt frozen during self refresh, which refreshes internally
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_q <= 16'h0000;
      end else if (i_in_selfref || tick_q >= limit) begin
         tick_q <= 16'h0000;
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         owed_q <= 4'h0;
      end else begin
         case ({!i_in_selfref && tick_q >= limit, i_ref_issued})
            2'b10:   owed_q <= owed_q + 4'h1;
            2'b01:   owed_q <= (owed_q == 4'h0) ? 4'h0 : owed_q - 4'h1;
            default: owed_q <= owed_q;
         endcase
      end
   end

   // coarse 2x interval window holding at most sixteen commands
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         win_q     <= 17'h00000;
         win_cnt_q <= 5'h00;
      end else if (win_q >= {limit, 1'b1}) begin
         win_q     <= 17'h00000;
         win_cnt_q <= {4'h0, i_ref_issued};
      end else begin
         win_q     <= win_q + 17'h00001;
         win_cnt_q <= win_cnt_q + {4'h0, i_ref_issued};
      end
   end

   assign o_need      = owed_q != 4'h0;
   assign o_urgent    = owed_q >= 4'(MAX_POSTED - 1);   // R14 R15
   assign o_window_ok = win_cnt_q < 5'(MAX_REF_BURST);  // R16

   a_owed_bound: assert property (@(posedge i_core_clk) // R14
      disable iff (!i_rst_n) owed_q <= 4'(MAX_POSTED + 1))
      else $error("refresh debt overrun");
endmodule : sdwc_refresh_sched

// File: hw/sdwc_host.sv
// dram host: write, precharge, refresh and self refresh command sequencer
// Function
// R1 - write drives cs low, ras high, cas low, we low with bank and column
// R2 - address bit ten high on write asks auto precharge after burst
// R3 - address bit twelve picks chopped four or full eight when enabled
// R4 - device stores a byte only where its write mask is low
// R5 - wait row precharge time after precharge before touching that bank
// R6 - other bank access allowed during auto precharge within timing limits
// R7 - precharge bit ten high closes all banks, low closes one bank
// R8 - precharged bank needs activate before read or write; host issues no activate and writes a precharged bank directly
// R9 - device treats precharge of idle bank as no operation
// R10 - device times precharge from the latest precharge to that bank
// R11 - refresh address is internal; address pins ignored
// R12 - refresh on average every 7.8 us, or 3.9 us when hot
// R13 - only no operation or deselect until refresh cycle time passes
// R14 - never more than eight refreshes postponed
// R15 - postponed count across self refresh stays at eight or fewer
// R16 - at most sixteen refreshes within twice the average interval
// R17 - clock enable high on precharge, activate and refresh
// R18 - close all banks with all-bank precharge before refresh
// R19 - device keeps data in self refresh without clock
// R20 - first write waits 512 clocks after reference valid again
// R21 - self refresh may host clock or loop changes
// R22 - deselect blocks new commands, work in progress continues
// R23 - no operation blocks unwanted commands, work continues
// R24 - refresh with clock enable falling and banks idle enters self refresh
// R25 - chopped burst carries four beats, full burst eight, mask per beat
// R26 - clock enable high with no operation leaves self refresh
`timescale 1ns/10ps
module sdwc_host
   import sdwc_pkg::*;
#(
   parameter int DQ_W      = 16,
   parameter int REFI_NORM = REFI_NORM_CYC,
   parameter int REFI_HOT  = REFI_HOT_CYC
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   // user requests
   input  wire logic              i_req_valid,
   input  sdwc_req_t              i_req,
   output logic                   o_req_ready,
   // user write data, one beat per cycle
   input  wire logic [DQ_W-1:0]   i_wr_data,
   input  wire logic [DQ_W/8-1:0] i_wr_mask,
   output logic                   o_wr_take,
   // user config
   input  wire logic              i_otf_enable,
   input  wire logic              i_hot,
   input  wire logic              i_vref_floated,
   input  wire logic              i_vref_valid,
   // dram pins
   output sdwc_cmd_t              o_dram_cmd,
   output logic [DQ_W-1:0]        o_dq,
   output logic                   o_dq_oe,
   output logic [DQ_W/8-1:0]      o_byte_write_mask,
   // status
   output logic                   o_in_selfref
);
   initial begin
      if (DQ_W < 8 || DQ_W % 8 != 0)
         $error("sdwc_host: data width must be whole bytes");
   end

   typedef enum logic [2:0] {
      SDWC_IDLE    = 3'h0,
      SDWC_BURST   = 3'h1,
      SDWC_WAIT    = 3'h2,
      SDWC_REFPRE  = 3'h3,
      SDWC_SELF    = 3'h4
   } sdwc_state_t;

   function automatic sdwc_cmd_t mk_cmd(input logic [3:0]  cmd,
                                        input logic [2:0]  bank,
                                        input logic [13:0] addr,
                                        input logic        cke);
      mk_cmd.cmd  = cmd;
      mk_cmd.bank = bank;
      mk_cmd.addr = addr;
      mk_cmd.cke  = cke;
   endfunction : mk_cmd

   sdwc_state_t state_q;
   sdwc_cmd_t   cmd_q;
   logic [8:0]  wait_q;
   logic [3:0]  beats_q;
   logic [7:0]  open_q;
   logic [9:0]  vref_q;
   logic [1:0]  vsync_q;
   logic [1:0]  fsync_q;
   logic        sref_q;
   logic        ref_issued;
   logic        ref_need;
   logic        ref_urgent;
   logic        win_ok;
   logic        vref_wait;
   logic [DQ_W-1:0]   dq_q;
   logic [DQ_W/8-1:0] mask_q;
   logic        dq_oe_q;
   logic        ready_q;
   logic        take_q;
   logic [3:0]  nbeats;

   // pins from the far side pass two flops first
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         vsync_q <= 2'h0;
         fsync_q <= 2'h0;
      end else begin
         vsync_q <= {vsync_q[0], i_vref_valid};
         fsync_q <= {fsync_q[0], i_vref_floated};
      end
   end

   sdwc_refresh_sched #(
      .REFI_NORM (REFI_NORM),
      .REFI_HOT  (REFI_HOT)
   ) u_sched (
      .i_core_clk   (i_core_clk),
      .i_rst_n      (i_rst_n),
      .i_hot        (i_hot),
      .i_ref_issued (ref_issued),
      .i_in_selfref (sref_q),
      .o_need       (ref_need),
      .o_urgent     (ref_urgent),
      .o_window_ok  (win_ok)
   );

   // debt drops only when the refresh really issues: when urgent, or when no request is waiting
   assign ref_issued = state_q == SDWC_IDLE && ref_need && win_ok
                       && open_q == 8'h00 && (ref_urgent || !i_req_valid);
   assign vref_wait  = vref_q != 10'h000;
   // R25 chopped or full; without on-the-fly selection always full
   assign nbeats = (i_otf_enable && !i_req.full_burst) ?
                   4'(BEATS_CHOP) : 4'(BEATS_FULL);

   // main sequencer
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= SDWC_IDLE;
         cmd_q   <= mk_cmd(CMD_NOP, 3'h0, 14'h0000, 1'b1);
         wait_q  <= 9'h000;
         beats_q <= 4'h0;
         sref_q  <= 1'b0;
      end else begin
         cmd_q <= mk_cmd(CMD_NOP, 3'h0, 14'h0000, !sref_q); // R23
         case (state_q)
            SDWC_IDLE: begin
               if (ref_need && (ref_urgent || !i_req_valid) &&
                   open_q != 8'h00) begin
                  // R18 all-bank close before refresh, R17 cke high
                  cmd_q   <= mk_cmd(CMD_PRECHG, 3'h0,
                                    14'(1 << ALLBANK_BIT), 1'b1);
                  wait_q  <= 9'(RP_CYC);                   // R5
                  state_q <= SDWC_WAIT;
               end else if (ref_issued) begin
                  // R11 address zero, R12 R16 scheduled by debt
                  cmd_q   <= mk_cmd(CMD_REFRESH, 3'h0, 14'h0000, 1'b1);
                  wait_q  <= 9'(RFC_CYC);                  // R13
                  state_q <= SDWC_WAIT;
               end else if (i_req_valid) begin
                  case (i_req.kind)
                     SDWC_REQ_WRITE: begin
                        if (!vref_wait) begin               // R20
                           // R1 R2 R3 write encoding
                           cmd_q <= mk_cmd(CMD_WRITE, i_req.bank,
                              {1'b0, i_req.full_burst, 1'b0,
                               i_req.autoclose, 10'(i_req.col)}, 1'b1);
                           beats_q <= nbeats;
                           state_q <= SDWC_BURST;
                        end
                     end
                     SDWC_REQ_PRECHG: begin
                        // R7 one bank or all
                        cmd_q <= mk_cmd(CMD_PRECHG, i_req.bank,
                           14'({i_req.all_banks, 10'h000}), 1'b1);
                        wait_q  <= 9'(RP_CYC);              // R5 R10
                        state_q <= SDWC_WAIT;
                     end
                     SDWC_REQ_SELFREF: begin
                        if (open_q == 8'h00) begin
                           // R24 refresh with cke falling
                           cmd_q   <= mk_cmd(CMD_REFRESH, 3'h0,
                                             14'h0000, 1'b0);
                           sref_q  <= 1'b1;
                           state_q <= SDWC_SELF;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            SDWC_BURST: begin
               beats_q <= beats_q - 4'h1;
               if (beats_q == 4'h1) begin
                  state_q <= SDWC_IDLE;
               end
            end
            SDWC_WAIT: begin
               wait_q <= wait_q - 9'h001;
               if (wait_q <= 9'h001) begin
                  state_q <= SDWC_IDLE;
               end
            end
            SDWC_SELF: begin
               // R19 R21 device holds data; clock may change meanwhile
               cmd_q <= mk_cmd(CMD_NOP, 3'h0, 14'h0000, 1'b0);
               if (i_req_valid && i_req.kind == SDWC_REQ_SREXIT) begin
                  // R26 cke high with a no operation
                  cmd_q   <= mk_cmd(CMD_NOP, 3'h0, 14'h0000, 1'b1);
                  sref_q  <= 1'b0;
                  wait_q  <= 9'(RFC_CYC);
                  state_q <= SDWC_WAIT;
               end
            end
            default: state_q <= SDWC_IDLE;
         endcase
      end
   end

   // bank open tracking: writes assume prior activation elsewhere
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         open_q <= 8'h00;
      end else if (cmd_q.cmd == CMD_PRECHG) begin
         if (cmd_q.addr[ALLBANK_BIT])
            open_q <= 8'h00;                                // R7
         else
            open_q[cmd_q.bank] <= 1'b0;                     // R8
      end else if (cmd_q.cmd == CMD_WRITE) begin
         // auto precharge marks the row closed the cycle after the write issues, with its first beat
         open_q[cmd_q.bank] <= !cmd_q.addr[ALLBANK_BIT];    // R2 R6
      end
   end

   // reference settle counter after self refresh
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         vref_q <= 10'h000;
      end else if (sref_q && fsync_q[1]) begin
         vref_q <= 10'(VREF_WR_CLKS);
      end else if (vref_wait && vsync_q[1]) begin
         vref_q <= vref_q - 10'h001;                        // R20
      end
   end

   // write data path, mask per lane per beat
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dq_q    <= '0;
         mask_q  <= '1;
         dq_oe_q <= 1'b0;
         take_q  <= 1'b0;
      end else begin
         take_q  <= state_q == SDWC_BURST;
         dq_oe_q <= state_q == SDWC_BURST;
         dq_q    <= i_wr_data;
         mask_q  <= (state_q == SDWC_BURST) ? i_wr_mask : '1; // R4 R25
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         ready_q <= 1'b0;
      else
         // self refresh still accepts its exit request
         ready_q <= state_q == SDWC_IDLE || state_q == SDWC_SELF;
   end

   assign o_req_ready       = ready_q;
   assign o_wr_take         = take_q;
   assign o_dram_cmd        = cmd_q;
   assign o_dq              = dq_q;
   assign o_dq_oe           = dq_oe_q;
   assign o_byte_write_mask = mask_q;
   assign o_in_selfref      = sref_q;

   a_refresh_quiet: assert property (@(posedge i_core_clk) // R13
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_REFRESH && cmd_q.cke) |=>
      (cmd_q.cmd == CMD_NOP || cmd_q.cmd == CMD_DESELECT) [*2])
      else $error("command during refresh cycle");
   a_cke_on_cmds: assert property (@(posedge i_core_clk) // R17
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_PRECHG) |-> cmd_q.cke)
      else $error("cke low on precharge");
   a_close_before_ref: assert property (@(posedge i_core_clk) // R18
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_REFRESH) |-> open_q == 8'h00)
      else $error("refresh with open bank");
   a_write_encode: assert property (@(posedge i_core_clk) // R1
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_WRITE) |-> cmd_q.cke &&
      cmd_q.bank == $past(i_req.bank) &&
      cmd_q.addr[9:0] == $past(i_req.col))
      else $error("write fields differ from request");
   a_write_autoclose: assert property (@(posedge i_core_clk) // R2
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_WRITE && cmd_q.addr[ALLBANK_BIT]) |=>
      !open_q[$past(cmd_q.bank)])
      else $error("auto precharge left bank open");
   a_otf_chop: assert property (@(posedge i_core_clk) // R3
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_WRITE && $past(i_otf_enable) &&
      !cmd_q.addr[BURST_SEL_BIT]) |-> beats_q == 4'(BEATS_CHOP))
      else $error("burst select bit ignored");
   a_burst_length: assert property (@(posedge i_core_clk) // R25
      disable iff (!i_rst_n)
      $rose(dq_oe_q) |-> dq_oe_q [*4])
      else $error("burst shorter than four beats");
   a_chop_burst: assert property (@(posedge i_core_clk) // R25
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_WRITE && beats_q == 4'(BEATS_CHOP)) |=>
      dq_oe_q [*4] ##1 !dq_oe_q)
      else $error("chopped burst not four beats");
   a_full_burst: assert property (@(posedge i_core_clk) // R25
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_WRITE && beats_q == 4'(BEATS_FULL)) |=>
      dq_oe_q [*8] ##1 !dq_oe_q)
      else $error("full burst not eight beats");
   a_prechg_one: assert property (@(posedge i_core_clk) // R7
      disable iff (!i_rst_n)
      (cmd_q.cmd == CMD_PRECHG && !cmd_q.addr[ALLBANK_BIT]) |=>
      !open_q[$past(cmd_q.bank)])
      else $error("precharged bank still open");
   a_vref_gate: assert property (@(posedge i_core_clk) // R20
      disable iff (!i_rst_n)
      vref_wait |=> cmd_q.cmd != CMD_WRITE)
      else $error("write before reference settled");
   a_selfref_entry: assert property (@(posedge i_core_clk) // R24
      disable iff (!i_rst_n)
      $rose(sref_q) |-> cmd_q.cmd == CMD_REFRESH && !cmd_q.cke)
      else $error("bad self refresh entry");
   a_selfref_exit: assert property (@(posedge i_core_clk) // R26
      disable iff (!i_rst_n)
      $fell(sref_q) |-> cmd_q.cmd == CMD_NOP && cmd_q.cke)
      else $error("bad self refresh exit");
   a_selfref_cke: assert property (@(posedge i_core_clk) // R19
      disable iff (!i_rst_n)
      sref_q |-> !cmd_q.cke)
      else $error("cke high in self refresh");
endmodule : sdwc_host

// File: verification/sdwc_dram_model.sv
// device model: pin decode, masked byte store and refresh rule checks
`timescale 1ns/10ps
module sdwc_dram_model
   import sdwc_pkg::*;
#(
   parameter int DQ_W      = 16,
   parameter int REFI_NORM = REFI_NORM_CYC,
   parameter int REFI_HOT  = REFI_HOT_CYC
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   // dram pins
   input  wire sdwc_cmd_t         i_cmd,
   input  wire logic [DQ_W-1:0]   i_dq,
   input  wire logic              i_dq_oe,
   input  wire logic [DQ_W/8-1:0] i_mask,
   input  wire logic              i_hot,
   // observation
   output logic [7:0]             o_viol,
   output logic [15:0]            o_refs,
   output logic                   o_in_sr,
   output logic [7:0]             o_open
);
   logic [7:0] mem [int];
   int         rp [8];
   int         ts [16];
   int         rfc, gap, cyc, ptr, beat, refi, wkey;
   logic       cke_q;

   // violations survive a reset so a mid-run reset cannot hide them
   initial o_viol = 8'h00;
   initial o_refs = 16'h0000;

   function automatic logic [7:0] peek(input int key);
      return mem.exists(key) ? mem[key] : 8'h00;
   endfunction : peek

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_in_sr = 1'b0;
         o_open  = 8'h00;
         rp      = '{default: 0};
         ts      = '{default: -1000};
         {rfc, gap, cyc, ptr, beat, wkey} = '0;
         cke_q   = 1'b1;
      end else begin
         cyc  = cyc + 1;
         refi = i_hot ? REFI_HOT : REFI_NORM;
         rfc  = (rfc > 0) ? rfc - 1 : 0;
         for (int b = 0; b < 8; b++) begin
            rp[b] = (rp[b] > 0) ? rp[b] - 1 : 0;
         end
         if (i_dq_oe) begin
            for (int l = 0; l < DQ_W / 8; l++) begin
               if (!i_mask[l]) begin
                  mem[(wkey + beat) * 8 + l] = i_dq[8*l +: 8];
               end
            end
            beat++;
         end
         if (o_in_sr) begin
            // contents persist with no commands decoded
            if (i_cmd.cke) begin
               o_in_sr = 1'b0;
               if (!(i_cmd.cmd inside {CMD_NOP, CMD_DESELECT})) o_viol++;
            end
         end else begin
            // time in self refresh is not counted as debt
            gap = gap + 1;
            if (gap == 9 * refi + 1) o_viol++;
            if (rfc > 0 && !(i_cmd.cmd inside {CMD_NOP, CMD_DESELECT}))
               o_viol++;
            if (i_cmd.cmd inside {CMD_PRECHG, CMD_REFRESH} && !cke_q)
               o_viol++;
            case (i_cmd.cmd)
               CMD_WRITE: begin
                  if (rp[i_cmd.bank] > 0) o_viol++;
                  o_open[i_cmd.bank] = !i_cmd.addr[10];
                  wkey = {i_cmd.bank, i_cmd.addr[9:0]};
                  beat = 0;
               end
               CMD_PRECHG: begin
                  if (!i_cmd.cke) o_viol++;
                  for (int b = 0; b < 8; b++) begin
                     if ((i_cmd.addr[10] || i_cmd.bank == b) &&
                         (o_open[b] || rp[b] > 0)) begin
                        o_open[b] = 1'b0;
                        rp[b]     = RP_CYC;
                     end
                  end
               end
               CMD_REFRESH: begin
                  if (o_open != 8'h00) o_viol++;
                  if (cyc - ts[ptr] < 2 * refi) o_viol++;
                  ts[ptr] = cyc;
                  ptr     = (ptr + 1) % 16;
                  o_refs++;
                  gap     = 0;
                  rfc     = RFC_CYC;
                  o_in_sr = !i_cmd.cke;
               end
               default: ;
            endcase
         end
         cke_q = i_cmd.cke;
      end
   end
endmodule : sdwc_dram_model

// File: verification/sdwc_host_bench.sv
// self-checking bench for the dram host with a device model on its pins
`timescale 1ns/10ps
module sdwc_host_bench
   import sdwc_pkg::*;
;
   localparam int REFI_N = 16;
   localparam int REFI_H = 8;
   localparam int LIMIT  = 20000;
   typedef struct packed {
      logic [2:0]  bank;
      logic [9:0]  col;
      logic        ac;
      logic        fb;
      logic        otf;
      logic [15:0] data;
      logic [1:0]  mask;
   } sdwc_row_t;
   sdwc_row_t   rows [6];
   logic        clk, rst_n, req_valid, ready, wr_take, otf, hot;
   logic        vfl, vval, dq_oe, in_sr, m_sr;
   sdwc_req_t   req;
   sdwc_cmd_t   cmd, seen;
   logic [15:0] wr_data, dq, refs;
   logic [1:0]  wr_mask, bwm;
   logic [7:0]  viol, m_open, e;
   int          num_errors, checks_done, cyc, stamp, takes, t0, n0;

   sdwc_host #(.DQ_W(16), .REFI_NORM(REFI_N), .REFI_HOT(REFI_H)) DUT (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid),
      .i_req(req), .o_req_ready(ready), .i_wr_data(wr_data),
      .i_wr_mask(wr_mask), .o_wr_take(wr_take), .i_otf_enable(otf),
      .i_hot(hot), .i_vref_floated(vfl), .i_vref_valid(vval),
      .o_dram_cmd(cmd), .o_dq(dq), .o_dq_oe(dq_oe),
      .o_byte_write_mask(bwm), .o_in_selfref(in_sr));
   sdwc_dram_model #(.DQ_W(16), .REFI_NORM(REFI_N), .REFI_HOT(REFI_H)) MODEL (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd), .i_dq(dq),
      .i_dq_oe(dq_oe), .i_mask(bwm), .i_hot(hot), .o_viol(viol),
      .o_refs(refs), .o_in_sr(m_sr), .o_open(m_open));

   task automatic end_sim();
      if (num_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   // request is held until its command shows, refresh may slip in first
   task automatic send(input sdwc_req_t rq, input logic [3:0] ec,
                       input logic ek);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 300);
      chk(n < 300, 1);
      req       <= rq;
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!((cmd.cmd === ec || (ec === CMD_NOP &&
         cmd.cmd === CMD_DESELECT)) && cmd.cke === ek &&
         cmd.bank === rq.bank) && n < 800);
      chk(n < 800, 1);
      seen      = cmd;
      stamp     = cyc;
      req_valid <= 1'b0;
   endtask : send

   task automatic do_write(input logic [2:0] b, input logic [9:0] c,
                           input logic ac, input logic fb);
      send(sdwc_req_t'{SDWC_REQ_WRITE, b, c, ac, fb, 1'h0}, CMD_WRITE, 1'h1);
      takes = 0;
      repeat (12) begin
         @(posedge clk);
         takes += (wr_take === 1'b1);
      end
   endtask : do_write

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         num_errors++;
         end_sim();
      end
   end

   initial begin
      clk         = 1'b0;
      rst_n       = 1'b0;
      req_valid   = 1'b0;
      req         = '0;
      {otf, hot, vfl, vval} = 4'h1;
      wr_data     = 16'h0000;
      wr_mask     = 2'h0;
      {num_errors, checks_done, cyc} = '0;
      rows = '{'{3'h0, 10'h010, 1'h0, 1'h0, 1'h1, 16'hA1B2, 2'h0},
               '{3'h1, 10'h020, 1'h0, 1'h1, 1'h1, 16'hC3D4, 2'h1},
               '{3'h2, 10'h030, 1'h1, 1'h0, 1'h1, 16'h5566, 2'h2},
               '{3'h3, 10'h040, 1'h1, 1'h1, 1'h1, 16'h7788, 2'h3},
               '{3'h4, 10'h3F8, 1'h0, 1'h0, 1'h0, 16'h99AA, 2'h0},
               '{3'h7, 10'h050, 1'h1, 1'h1, 1'h0, 16'hBBCC, 2'h1}};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         otf     <= rows[i].otf;
         wr_data <= rows[i].data;
         wr_mask <= rows[i].mask;
         do_write(rows[i].bank, rows[i].col, rows[i].ac, rows[i].fb);
         chk(seen.bank, rows[i].bank);
         chk(seen.addr[9:0], rows[i].col);
         chk(seen.addr[10], rows[i].ac);
         if (rows[i].otf) chk(seen.addr[12], rows[i].fb);
         n0 = (rows[i].otf && !rows[i].fb) ? BEATS_CHOP : BEATS_FULL;
         chk(takes, n0);
         for (int b = 0; b < 8; b++) begin
            for (int l = 0; l < 2; l++) begin
               e = (b < n0 && !rows[i].mask[l]) ? rows[i].data[8*l +: 8] : 0;
               t0 = (rows[i].bank * 1024 + rows[i].col + b) * 8 + l;
               chk(MODEL.peek(t0), e);
            end
         end
      end
      // mid-run reset puts the pins back to their quiet values
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({cmd.cmd, cmd.cke, dq_oe, bwm, ready}, {CMD_NOP, 5'h16});
      rst_n <= 1'b1;
      do_write(3'h5, 10'h100, 1'h0, 1'h1);
      send(sdwc_req_t'{SDWC_REQ_PRECHG, 3'h5, 10'h000, 1'h0, 1'h0, 1'h0},
           CMD_PRECHG, 1'h1);
      chk({seen.addr[10], seen.bank}, 4'h5);
      do_write(3'h5, 10'h108, 1'h0, 1'h1);
      do_write(3'h6, 10'h100, 1'h0, 1'h1);
      send(sdwc_req_t'{SDWC_REQ_PRECHG, 3'h3, 10'h000, 1'h0, 1'h0, 1'h1},
           CMD_PRECHG, 1'h1);
      @(posedge clk);
      chk({seen.addr[10], m_open}, 9'h100);
      for (int h = 0; h < 2; h++) begin
         hot <= h[0];
         @(posedge clk);
         n0 = refs;
         repeat (400) @(posedge clk);
         t0 = 400 / (h ? REFI_H : REFI_N) - MAX_POSTED - 1;
         chk(refs - n0 >= t0, 1);
      end
      hot     <= 1'b0;
      wr_data <= 16'h5AC3;
      wr_mask <= 2'h0;
      do_write(3'h1, 10'h200, 1'h1, 1'h1);
      send(sdwc_req_t'{SDWC_REQ_SELFREF, 3'h0, 10'h000, 1'h0, 1'h0, 1'h0},
           CMD_REFRESH, 1'h0);
      vfl  <= 1'b1;
      vval <= 1'b0;
      n0 = 0;
      repeat (60) begin
         @(posedge clk);
         n0 += (cmd.cke !== 1'b0);
      end
      chk(n0, 0);
      chk({in_sr, m_sr}, 2'h3);
      vval <= 1'b1;
      t0 = cyc;
      send(sdwc_req_t'{SDWC_REQ_SREXIT, 3'h0, 10'h000, 1'h0, 1'h0, 1'h0},
           CMD_NOP, 1'h1);
      do_write(3'h2, 10'h300, 1'h0, 1'h1);
      chk(stamp - t0 >= VREF_WR_CLKS, 1);
      chk({in_sr, m_sr}, 2'h0);
      vfl <= 1'b0;
      chk(MODEL.peek((1024 + 512 + 3) * 8 + 1), 8'h5A);
      chk(viol, 0);
      end_sim();
   end
endmodule : sdwc_host_bench
